/* File: logic/cpts_top.sv */
/*
 * Cpu priority and trap status block: cpu control register with the upper
 * priority bit, interrupt control register one with nesting disable and
 * four trap flags, the three low priority bits, and a trap interrupt.
 * Assumes an APB master on pclk and trap and core inputs on pclk.
 */
//
// Behaviour
// - cpu control bit 3 shows priority above 7
// - level is high bit over low three bits
// - high bit resets 0; software may only clear
// - bit 15 nesting disable, read/write, reset 0
// - bit 4 set on arithmetic trap
// - bit 3 set on address trap
// - bit 2 set on stack trap
// - bit 1 set on oscillator failure trap
// - unimplemented bits read zero, ignore writes
// - high bit never set by software
// - low bits read-only while nesting disabled
// - low bits 111 blocks all user interrupts
`default_nettype none
`include "cpts_consts.svh"

module cpts_top (
    input wire logic pclk, // system clock, 10 MHz
    input wire logic presetn, // async reset, active low
    input wire cpts_pkg::cpts_apb_req_t apb_req, // APB request
    output cpts_pkg::cpts_apb_rsp_t apb_rsp, // APB answer
    input wire cpts_pkg::cpts_trap_t trap_in, // trap occurrences, high = trap
    input wire logic core_prio_load, // core loads a new level
    input wire logic [3:0] core_prio_value, // level loaded by the core
    output logic [3:0] prio_level, // current cpu priority level
    output logic nesting_disable, // 1 = nesting disabled
    output logic program_space_view, // program space view control
    output logic user_int_blocked, // low bits at 7
    output logic irq // trap interrupt, level
);
    import cpts_pkg::*;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    cpts_sel_t sel;
    logic setup;
    logic access;
    logic wr;
    logic rd;

    assign sel = cpts_decode(apb_req.paddr);
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr = access && apb_req.pwrite && !apb_rsp.pslverr;
    assign rd = access && !apb_req.pwrite && !apb_rsp.pslverr;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic prio_high_q;
    logic prio_high_d;
    logic [2:0] prio_low_q;
    logic [2:0] prio_low_d;
    logic nest_dis_q;
    logic psv_q;
    cpts_trap_t flags_q;
    cpts_trap_t flags_d;
    logic [3:0] level_q;
    logic blocked_q;
    cpts_trap_t clr_bits;
    cpts_trap_t irq_status;
    cpts_trap_t irq_mask;
    logic irq_w;
    logic [31:0] rdata;

    // ------------------------------------------------------------------------
    // upper priority bit
    // ------------------------------------------------------------------------
    // the core entering a trap outranks a software clear in the same cycle
    always_comb begin
        prio_high_d = prio_high_q;
        if (wr && sel == CPTS_SEL_CPU_CTRL && !apb_req.pwdata[`CPTS_BIT_PRIO_HIGH]) begin
            prio_high_d = 1'b0;
        end
        if (core_prio_load) begin
            prio_high_d = core_prio_value[3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_high_q <= `CPTS_RST_BIT;
        end else begin
            prio_high_q <= prio_high_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psv_q <= `CPTS_RST_BIT;
        end else if (wr && sel == CPTS_SEL_CPU_CTRL) begin
            psv_q <= apb_req.pwdata[`CPTS_BIT_PSV];
        end
    end

    // ------------------------------------------------------------------------
    // low priority bits
    // ------------------------------------------------------------------------
    always_comb begin
        prio_low_d = prio_low_q;
        if (wr && sel == CPTS_SEL_ALU_STAT && !nest_dis_q) begin
            prio_low_d = apb_req.pwdata[`CPTS_BIT_LOW_MSB:`CPTS_BIT_LOW_LSB];
        end
        if (core_prio_load) begin
            prio_low_d = core_prio_value[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_low_q <= `CPTS_RST_LOW;
        end else begin
            prio_low_q <= prio_low_d;
        end
    end

    // ------------------------------------------------------------------------
    // nesting disable and trap flags
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nest_dis_q <= `CPTS_RST_BIT;
        end else if (wr && sel == CPTS_SEL_INT_CTRL1) begin
            nest_dis_q <= apb_req.pwdata[`CPTS_BIT_NEST_DIS];
        end
    end

    // software may write the flags either way; a trap in the same cycle wins
    always_comb begin
        flags_d = flags_q;
        if (wr && sel == CPTS_SEL_INT_CTRL1) begin
            flags_d = cpts_word_trap(apb_req.pwdata);
        end
        flags_d = flags_d | trap_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `CPTS_RST_TRAPS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------------------
    // level outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= {`CPTS_RST_BIT, `CPTS_RST_LOW};
            blocked_q <= `CPTS_RST_BIT;
        end else begin
            level_q <= {prio_high_d, prio_low_d};
            blocked_q <= (prio_low_d == `CPTS_PRIO_LOW_MAX);
        end
    end

    // ------------------------------------------------------------------------
    // read data and bus answer
    // ------------------------------------------------------------------------
    always_comb begin
        rdata = `CPTS_RST_WORD;
        unique case (sel)
            CPTS_SEL_CPU_CTRL: begin
                rdata[`CPTS_BIT_PRIO_HIGH] = prio_high_q;
                rdata[`CPTS_BIT_PSV] = psv_q;
            end
            CPTS_SEL_INT_CTRL1: begin
                rdata = cpts_trap_word(flags_q);
                rdata[`CPTS_BIT_NEST_DIS] = nest_dis_q;
            end
            CPTS_SEL_ALU_STAT: begin
                rdata[`CPTS_BIT_LOW_MSB:`CPTS_BIT_LOW_LSB] = prio_low_q;
            end
            CPTS_SEL_IRQ_STAT: begin
                rdata = cpts_trap_word(irq_status);
            end
            CPTS_SEL_IRQ_MASK: begin
                rdata = cpts_trap_word(irq_mask);
            end
            CPTS_SEL_NONE: begin
                rdata = `CPTS_RST_WORD;
            end
        endcase
    end

    // zero wait states: answer is ready in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= setup;
            if (setup) begin
                apb_rsp.prdata <= apb_req.pwrite ? `CPTS_RST_WORD : rdata;
                apb_rsp.pslverr <= (sel == CPTS_SEL_NONE);
            end
        end
    end

    // ------------------------------------------------------------------------
    // trap interrupt
    // ------------------------------------------------------------------------
    // clearing only what was latched keeps an event of the setup cycle alive
    assign clr_bits = (rd && sel == CPTS_SEL_IRQ_STAT) ? cpts_word_trap(apb_rsp.prdata)
                                                       : `CPTS_RST_TRAPS;

    cpts_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .events(trap_in),
        .clr_bits(clr_bits),
        .mask_we(wr && sel == CPTS_SEL_IRQ_MASK),
        .mask_wdata(cpts_word_trap(apb_req.pwdata)),
        .status_q(irq_status),
        .mask_q(irq_mask),
        .irq_q(irq_w)
    );

    assign prio_level = level_q;
    assign nesting_disable = nest_dis_q;
    assign program_space_view = psv_q;
    assign user_int_blocked = blocked_q;
    assign irq = irq_w;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_HIGH_READ: assert property (
        setup && !apb_req.pwrite && sel == CPTS_SEL_CPU_CTRL
        |=> apb_rsp.prdata[`CPTS_BIT_PRIO_HIGH] == $past(prio_high_q))
        else $error("cpu control bit 3 does not show the high priority bit");

    AST_LEVEL_JOIN: assert property (
        ##1 prio_level == {prio_high_q, prio_low_q})
        else $error("priority level is not high bit over low bits");

    AST_NO_SW_SET: assert property (
        !prio_high_q && !core_prio_load |=> !prio_high_q)
        else $error("software raised the high priority bit");

    AST_SW_CLEAR: assert property (
        wr && sel == CPTS_SEL_CPU_CTRL && !apb_req.pwdata[`CPTS_BIT_PRIO_HIGH]
        && !core_prio_load |=> !prio_high_q && !prio_level[3])
        else $error("high priority bit not cleared by software");

    AST_NEST_WRITE: assert property (
        wr && sel == CPTS_SEL_INT_CTRL1
        |=> nesting_disable == $past(apb_req.pwdata[`CPTS_BIT_NEST_DIS]))
        else $error("nesting disable did not take the written value");

    AST_ARITH_SET: assert property (
        trap_in.arith |=> flags_q.arith)
        else $error("arithmetic trap flag not set");

    AST_ADDR_SET: assert property (
        trap_in.addr |=> flags_q.addr ##1 (flags_q.addr || $past(wr)))
        else $error("address trap flag not set or lost");

    AST_STACK_SET: assert property (
        $rose(trap_in.stack) |=> flags_q.stack)
        else $error("stack trap flag not set");

    AST_OSC_SET: assert property (
        trap_in.osc ##1 !(wr && sel == CPTS_SEL_INT_CTRL1) |=> flags_q.osc)
        else $error("oscillator failure flag not held");

    AST_UNUSED_ZERO: assert property (
        setup && !apb_req.pwrite && sel == CPTS_SEL_CPU_CTRL
        |=> (apb_rsp.prdata & 32'hffff_fff3) == 32'h0000_0000)
        else $error("unimplemented cpu control bits read nonzero");

    AST_LOW_LOCKED: assert property (
        nest_dis_q && !core_prio_load |=> $stable(prio_low_q))
        else $error("low priority bits changed while nesting disabled");

    AST_BLOCKED: assert property (
        prio_low_q == `CPTS_PRIO_LOW_MAX |-> user_int_blocked)
        else $error("level 7 does not block user interrupts");

    // bus answer: one access cycle, zero data on writes, error only when unmapped
    AST_ZERO_WAIT: assert property (
        setup |=> apb_rsp.pready)
        else $error("access phase came without ready");

    AST_SLVERR: assert property (
        setup |=> apb_rsp.pslverr == ($past(sel) == CPTS_SEL_NONE))
        else $error("bus error does not match the address decode");

    AST_WRITE_DATA_ZERO: assert property (
        setup && apb_req.pwrite |=> apb_rsp.prdata == `CPTS_RST_WORD)
        else $error("write answer carried nonzero read data");

    AST_PSV_WRITE: assert property (
        wr && sel == CPTS_SEL_CPU_CTRL
        |=> program_space_view == $past(apb_req.pwdata[`CPTS_BIT_PSV]))
        else $error("program space view did not take the written value");

    AST_CORE_LOAD: assert property (
        core_prio_load |=> prio_level == $past(core_prio_value))
        else $error("core load did not set the priority level");

    AST_LOW_WRITE: assert property (
        wr && sel == CPTS_SEL_ALU_STAT && !nest_dis_q && !core_prio_load
        |=> prio_low_q == $past(apb_req.pwdata[`CPTS_BIT_LOW_MSB:`CPTS_BIT_LOW_LSB]))
        else $error("low priority bits did not take the written value");

    AST_NOT_BLOCKED: assert property (
        prio_low_q != `CPTS_PRIO_LOW_MAX |-> !user_int_blocked)
        else $error("user interrupts blocked below level 7");

    // the flag checks allow for a trap arriving in the write's own cycle
    AST_FLAG_WRITE: assert property (
        wr && sel == CPTS_SEL_INT_CTRL1
        |=> flags_q == ($past(cpts_word_trap(apb_req.pwdata)) | $past(trap_in)))
        else $error("trap flags do not follow the write merged with new traps");

    AST_FLAG_HOLD: assert property (
        !(wr && sel == CPTS_SEL_INT_CTRL1) && trap_in == `CPTS_RST_TRAPS |=> $stable(flags_q))
        else $error("trap flags changed with no trap and no write");

    AST_IC1_UNUSED_ZERO: assert property (
        setup && !apb_req.pwrite && sel == CPTS_SEL_INT_CTRL1
        |=> (apb_rsp.prdata & 32'hffff_7fe1) == 32'h0000_0000)
        else $error("unimplemented interrupt control one bits read nonzero");

    COV_TRAP_IRQ: cover property (trap_in.arith ##1 irq_mask.arith ##[1:3] irq);
    COV_CLEAR_HIGH: cover property (prio_high_q ##1 !prio_high_q);
    COV_LOCKED_WRITE: cover property (wr && sel == CPTS_SEL_ALU_STAT && nest_dis_q);
    COV_SET_BEATS_CLR: cover property (wr && sel == CPTS_SEL_INT_CTRL1 && trap_in.stack);
    COV_CORE_HIGH: cover property (core_prio_load && core_prio_value[3]);

endmodule : cpts_top

`default_nettype wire

/* File: logic/cpts_consts.svh */
/*
 * Register offsets, bit positions and reset values of the cpu priority and
 * trap status block. Assumes inclusion by its bare name from logic/.
 */
`ifndef CPTS_CONSTS_SVH
`define CPTS_CONSTS_SVH

// ----------------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------------
`define CPTS_OFS_CPU_CTRL 8'h00
`define CPTS_OFS_INT_CTRL1 8'h04
`define CPTS_OFS_ALU_STAT 8'h08
`define CPTS_OFS_IRQ_STAT 8'h0c
`define CPTS_OFS_IRQ_MASK 8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CPTS_BIT_PRIO_HIGH 3
`define CPTS_BIT_PSV 2
`define CPTS_BIT_NEST_DIS 15
`define CPTS_BIT_ARITH 4
`define CPTS_BIT_ADDR 3
`define CPTS_BIT_STACK 2
`define CPTS_BIT_OSC 1
`define CPTS_BIT_LOW_MSB 7
`define CPTS_BIT_LOW_LSB 5
`define CPTS_PRIO_LOW_MAX 3'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPTS_RST_BIT 1'b0
`define CPTS_RST_LOW 3'h0
`define CPTS_RST_TRAPS 4'h0
`define CPTS_RST_WORD 32'h0000_0000

`endif

/* File: logic/cpts_pkg.sv */
/*
 * Types of the cpu priority and trap status block: trap vector, APB request
 * and answer carriers, register select and its decoder.
 * Assumes cpts_consts.svh sits beside it.
 */
`default_nettype none
`include "cpts_consts.svh"

package cpts_pkg;

    typedef struct packed {
        logic arith;
        logic addr;
        logic stack;
        logic osc;
    } cpts_trap_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cpts_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cpts_apb_rsp_t;

    typedef enum logic [2:0] {
        CPTS_SEL_CPU_CTRL,
        CPTS_SEL_INT_CTRL1,
        CPTS_SEL_ALU_STAT,
        CPTS_SEL_IRQ_STAT,
        CPTS_SEL_IRQ_MASK,
        CPTS_SEL_NONE
    } cpts_sel_t;

    function automatic cpts_sel_t cpts_decode(input logic [7:0] addr);
        unique case (addr)
            `CPTS_OFS_CPU_CTRL: cpts_decode = CPTS_SEL_CPU_CTRL;
            `CPTS_OFS_INT_CTRL1: cpts_decode = CPTS_SEL_INT_CTRL1;
            `CPTS_OFS_ALU_STAT: cpts_decode = CPTS_SEL_ALU_STAT;
            `CPTS_OFS_IRQ_STAT: cpts_decode = CPTS_SEL_IRQ_STAT;
            `CPTS_OFS_IRQ_MASK: cpts_decode = CPTS_SEL_IRQ_MASK;
            default: cpts_decode = CPTS_SEL_NONE;
        endcase
    endfunction : cpts_decode

    // trap vector placed at its register bit positions
    function automatic logic [31:0] cpts_trap_word(input cpts_trap_t t);
        logic [31:0] w;
        w = `CPTS_RST_WORD;
        w[`CPTS_BIT_ARITH] = t.arith;
        w[`CPTS_BIT_ADDR] = t.addr;
        w[`CPTS_BIT_STACK] = t.stack;
        w[`CPTS_BIT_OSC] = t.osc;
        return w;
    endfunction : cpts_trap_word

    function automatic cpts_trap_t cpts_word_trap(input logic [31:0] w);
        cpts_trap_t t;
        t.arith = w[`CPTS_BIT_ARITH];
        t.addr = w[`CPTS_BIT_ADDR];
        t.stack = w[`CPTS_BIT_STACK];
        t.osc = w[`CPTS_BIT_OSC];
        return t;
    endfunction : cpts_word_trap

endpackage : cpts_pkg

`default_nettype wire

/* File: logic/cpts_irq.sv */
/*
 * Sticky trap interrupt status, its mask and the level interrupt output.
 * Assumes events and the clear vector come from logic on pclk.
 */
`default_nettype none
`include "cpts_consts.svh"

module cpts_irq (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire cpts_pkg::cpts_trap_t events, // trap events this cycle
    input wire cpts_pkg::cpts_trap_t clr_bits, // bits read out, to clear
    input wire logic mask_we, // mask write strobe
    input wire cpts_pkg::cpts_trap_t mask_wdata, // new mask
    output cpts_pkg::cpts_trap_t status_q, // sticky status
    output cpts_pkg::cpts_trap_t mask_q, // mask, 1 passes
    output logic irq_q // level interrupt
);
    import cpts_pkg::*;

    cpts_trap_t status_d;

    // only bits that software actually saw are cleared, and a new event wins
    assign status_d = (status_q & ~clr_bits) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `CPTS_RST_TRAPS;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `CPTS_RST_TRAPS;
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= `CPTS_RST_BIT;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        irq_q == $past(|(status_q & mask_q)))
        else $error("interrupt output does not follow unmasked status");

endmodule : cpts_irq

`default_nettype wire

/* File: testbench/cpts_core_model.sv */
/*
 * Model of the cpu core and the hardware trap sources beside the block.
 * Assumes its tasks are called by the testbench, right after a pclk edge.
 */
`default_nettype none

module cpts_core_model (
    input wire logic pclk, // system clock
    output cpts_pkg::cpts_trap_t trap_in, // trap occurrences, high = trap
    output logic core_prio_load, // level load strobe
    output logic [3:0] core_prio_value // level to load
);
    import cpts_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        trap_in = '0;
        core_prio_load = 1'b0;
        core_prio_value = 4'h5;
    end

    // ------------------------------------------------------------------
    // trap source: one vector bit held high for n edges
    // ------------------------------------------------------------------
    task trap(input int j, input int n);
        @(posedge pclk);
        trap_in <= cpts_trap_t'(4'h1 << j);
        repeat (n) @(posedge pclk);
        trap_in <= '0;
    endtask : trap

    // ------------------------------------------------------------------
    // core level load; the value is scrambled once the strobe is gone
    // ------------------------------------------------------------------
    task load(input logic [3:0] val);
        @(posedge pclk);
        core_prio_load <= 1'b1;
        core_prio_value <= val;
        @(posedge pclk);
        core_prio_load <= 1'b0;
        core_prio_value <= ~val;
    endtask : load

endmodule : cpts_core_model

`default_nettype wire

/* File: testbench/test_cpu_priority_and_trap_status.sv */
/*
 * Self-checking testbench of the cpu priority and trap status block.
 * Assumes the package and design under logic/ and cpts_core_model.
 */
`default_nettype none
`include "cpts_consts.svh"

module test_cpu_priority_and_trap_status;
    import cpts_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] A_CPU = `CPTS_OFS_CPU_CTRL;
    localparam logic [7:0] A_IC1 = `CPTS_OFS_INT_CTRL1;
    localparam logic [7:0] A_ALU = `CPTS_OFS_ALU_STAT;
    localparam logic [7:0] A_STA = `CPTS_OFS_IRQ_STAT;
    localparam logic [7:0] A_MSK = `CPTS_OFS_IRQ_MASK;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    cpts_apb_req_t req = '0;
    cpts_apb_rsp_t rsp;
    cpts_trap_t trap_in;
    logic core_prio_load;
    logic [3:0] core_prio_value;
    logic [3:0] prio_level;
    logic nesting_disable, program_space_view, user_int_blocked, irq;
    int fails = 0;
    int cmp_count = 0;
    int seed = 32'h392b9a8a;
    logic [31:0] rd, v, v2;
    logic [2:0] low;
    logic err;

    always #50 pclk = ~pclk;

    cpts_top DUT (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .trap_in(trap_in), .core_prio_load(core_prio_load),
        .core_prio_value(core_prio_value), .prio_level(prio_level),
        .nesting_disable(nesting_disable), .program_space_view(program_space_view),
        .user_int_blocked(user_int_blocked), .irq(irq)
    );

    cpts_core_model u_core (
        .pclk(pclk), .trap_in(trap_in), .core_prio_load(core_prio_load),
        .core_prio_value(core_prio_value)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // ------------------------------------------------------------------
    // APB master; an idle edge precedes each setup so no strobe is
    // assigned twice in one time step
    // ------------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // implemented bits of interrupt control one
    function automatic logic [31:0] exp_ic1(input logic [31:0] w);
        return w & 32'h0000_801e;
    endfunction : exp_ic1

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_CPU, 32'h0);
        rdchk(A_IC1, 32'h0);
        check(prio_level, 4'h0);
        $display("test reset values done");

        wr(A_IC1, 32'hffff_ffff);
        rdchk(A_IC1, 32'h0000_801e);
        check(nesting_disable, 1'b1);
        wr(A_ALU, 32'h0000_00e0);
        rdchk(A_ALU, 32'h0);
        wr(A_CPU, 32'hffff_ffff);
        rdchk(A_CPU, 32'h0000_0004);
        check(program_space_view, 1'b1);
        wr(A_CPU, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(err, 1'b1);
        $display("test unimplemented bits done");

        low = 3'h0;
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            v2 = $random(seed);
            if (i == 0) v2 = 32'h0000_00e0;
            wr(A_IC1, v);
            rdchk(A_IC1, exp_ic1(v));
            check(nesting_disable, v[15]);
            wr(A_ALU, v2);
            if (!v[15]) low = v2[7:5];
            rdchk(A_ALU, {24'h0, low, 5'h0});
            check(prio_level, {1'b0, low});
            check(user_int_blocked, low == 3'h7);
        end
        wr(A_IC1, 32'h0);
        $display("test random register traffic done");

        u_core.load(4'hb);
        rdchk(A_CPU, 32'h8);
        check(prio_level, 4'hb);
        wr(A_CPU, 32'h8);
        rdchk(A_CPU, 32'h8);
        wr(A_CPU, 32'h0);
        rdchk(A_CPU, 32'h0);
        check(prio_level, 4'h3);
        u_core.load(4'h7);
        rdchk(A_CPU, 32'h0);
        check(user_int_blocked, 1'b1);
        u_core.load(4'h8);
        rdchk(A_CPU, 32'h8);
        check(user_int_blocked, 1'b0);
        wr(A_CPU, 32'h0);
        $display("test priority level done");

        // start the trap loop from a clean sticky status
        apb(1'b0, A_STA, 32'h0);
        for (int j = 0; j < 4; j++) begin
            wr(A_MSK, 32'h0);
            u_core.trap(j, 1);
            repeat (2) @(posedge pclk);
            check(irq, 1'b0);
            rdchk(A_IC1, 32'h2 << j);
            wr(A_MSK, 32'h2 << j);
            rdchk(A_MSK, 32'h2 << j);
            repeat (2) @(posedge pclk);
            check(irq, 1'b1);
            rdchk(A_STA, 32'h2 << j);
            repeat (2) @(posedge pclk);
            check(irq, 1'b0);
            rdchk(A_STA, 32'h0);
            wr(A_IC1, 32'h0);
            rdchk(A_IC1, 32'h0);
        end
        $display("test trap flags done");

        // trap held high across the clearing write's access edge
        fork
            u_core.trap(3, 6);
            wr(A_IC1, 32'h0);
        join
        rdchk(A_IC1, 32'h10);
        wr(A_IC1, 32'h0);
        rdchk(A_IC1, 32'h0);
        $display("test trap against clear done");
        print_verdict();
    end

endmodule : test_cpu_priority_and_trap_status

`default_nettype wire
